// ==== encdiv_consts.svh ====
// Constants of the encoder counter and step divider
// Operation
// [RULE1] Status read refused while moving, values kept
// [RULE2] Unsigned 24-bit remaining step count per channel
// [RULE3] 24-bit up/down encoder counter per channel
// [RULE4] Count is signed; positive means clockwise
// [RULE5] Host reads three live bytes only at rest
// [RULE6] Counter cleared only by channel initialization
// [RULE7] Encoder counter independent of step logic
// [RULE8] Divider divides by loaded value plus one
// [RULE9] Divider steers steps only on reference source
// [RULE10] Host loads divider only with 1 to 255
// [RULE11] Two channels, one-bit selector picks channel
// [RULE12] Finish flag set, cleared by second read
`ifndef ENCDIV_CONSTS_SVH
`define ENCDIV_CONSTS_SVH

`define ENCDIV_CLK_HZ     32'h05F5_E100
`define ENCDIV_REF_HZ     32'h0001_86A0
`define ENCDIV_PRE_CYC    ((`ENCDIV_CLK_HZ) / (`ENCDIV_REF_HZ))
`define ENCDIV_PRE_MAX    (10'((`ENCDIV_PRE_CYC) - 32'h0000_0001))
`define ENCDIV_CNT_W      24
`define ENCDIV_DIV_W      8
`define ENCDIV_DIV_RST    8'h01
`define ENCDIV_DIV_MIN    8'h01
`define ENCDIV_BYTE_W     2

`endif

// ==== encdiv_pkg.sv ====
// Types of the encoder counter and step divider
package encdiv_pkg;

  typedef enum logic [5:0] {
    ENCDIV_CMD_MOVE   = 6'b00_0001,
    ENCDIV_CMD_STATUS = 6'b00_0010,
    ENCDIV_CMD_ENC    = 6'b00_0100,
    ENCDIV_CMD_FIN    = 6'b00_1000,
    ENCDIV_CMD_DIV    = 6'b01_0000,
    ENCDIV_CMD_INIT   = 6'b10_0000
  } encdiv_cmd_t;

  typedef struct packed {
    logic        a_s1;
    logic        a_s2;
    logic        b_s1;
    logic        b_s2;
    logic [1:0]  ab_prev;
    logic        x_s1;
    logic        x_s2;
    logic        x_prev;
    logic [23:0] enc;
    logic [23:0] remain;
    logic [7:0]  div_val;
    logic [7:0]  div_cnt;
    logic        ref_sel;
    logic        step;
    logic        done;
  } encdiv_chan_t;

  typedef struct packed {
    logic [9:0]       pre_cnt;
    logic             ref_tick;
    logic             rsp_valid;
    logic             rsp_busy;
    logic             rsp_err;
    logic [23:0]      rsp_data;
    logic [1:0][23:0] stat;
    logic [1:0]       fin;
    logic [1:0]       fin_seen;
  } encdiv_top_t;

endpackage : encdiv_pkg

// ==== encdiv_chan.sv ====
// One channel: encoder counter, step divider, remaining steps
`timescale 1ns/10ps
`include "encdiv_consts.svh"

module encdiv_chan (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        enc_a_pin,
  input  wire logic        enc_b_pin,
  input  wire logic        ext_step_pin,
  input  wire logic        ref_tick,
  input  wire logic        init_pulse,
  input  wire logic        init_ref_sel,
  input  wire logic        div_load,
  input  wire logic [7:0]  div_val,
  input  wire logic        move_load,
  input  wire logic [23:0] move_count,
  output logic      [23:0] enc_count,
  output logic      [23:0] remain,
  output logic             moving,
  output logic             step_pulse,
  output logic             done_pulse
);

  encdiv_pkg::encdiv_chan_t s_r;
  encdiv_pkg::encdiv_chan_t s_nxt;

  // Gray order 00,01,11,10 is clockwise
  function automatic logic [1:0] encdiv_qdir(input logic [1:0] p,
                                             input logic [1:0] c);
    unique case ({p, c})
      4'h1, 4'h7, 4'hE, 4'h8: encdiv_qdir = 2'h1;
      4'h2, 4'hB, 4'hD, 4'h4: encdiv_qdir = 2'h2;
      default:                encdiv_qdir = 2'h0;
    endcase
  endfunction : encdiv_qdir

  logic [1:0] qd;
  logic       div_tick;
  logic       src_tick;
  assign qd       = encdiv_qdir(s_r.ab_prev, {s_r.a_s2, s_r.b_s2});
  assign div_tick = ref_tick && (s_r.div_cnt == 8'h00);
  // [RULE9] Source select
  assign src_tick = s_r.ref_sel ? div_tick : (s_r.x_s2 && !s_r.x_prev);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt         = s_r;
    s_nxt.a_s1    = enc_a_pin;
    s_nxt.a_s2    = s_r.a_s1;
    s_nxt.b_s1    = enc_b_pin;
    s_nxt.b_s2    = s_r.b_s1;
    s_nxt.ab_prev = {s_r.a_s2, s_r.b_s2};
    s_nxt.x_s1    = ext_step_pin;
    s_nxt.x_s2    = s_r.x_s1;
    s_nxt.x_prev  = s_r.x_s2;
    s_nxt.step    = 1'b0;
    s_nxt.done    = 1'b0;
    // [RULE3] Up/down count
    // [RULE7] Encoder pins only, no motion flag
    if (qd == 2'h1) begin
      s_nxt.enc = s_r.enc + 24'h00_0001;
    end else if (qd == 2'h2) begin
      s_nxt.enc = s_r.enc - 24'h00_0001;
    end
    // [RULE8] Reload gives ratio plus one
    if (ref_tick) begin
      s_nxt.div_cnt = div_tick ? s_r.div_val : s_r.div_cnt - 8'h01;
    end
    if (div_load) begin
      s_nxt.div_val = div_val;
    end
    // [RULE2] Remaining steps count down
    if (move_load) begin
      s_nxt.remain = move_count;
      s_nxt.done   = (move_count == 24'h00_0000);
    end else if ((s_r.remain != 24'h00_0000) && src_tick) begin
      s_nxt.remain = s_r.remain - 24'h00_0001;
      s_nxt.step   = 1'b1;
      s_nxt.done   = (s_r.remain == 24'h00_0001);
    end
    // [RULE6] Clear only here
    if (init_pulse) begin
      s_nxt.enc     = 24'h00_0000;
      s_nxt.remain  = 24'h00_0000;
      s_nxt.div_cnt = 8'h00;
      s_nxt.ref_sel = init_ref_sel;
      s_nxt.step    = 1'b0;
      s_nxt.done    = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r         <= '0;
      s_r.div_val <= `ENCDIV_DIV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign enc_count  = s_r.enc;
  assign remain     = s_r.remain;
  assign moving     = (s_r.remain != 24'h00_0000);
  assign step_pulse = s_r.step;
  assign done_pulse = s_r.done;

  ////////////////////////////////////////////////////////////////////////
  a_enc_cw_up: assert property (@(posedge clk) disable iff (srst) // [RULE4]
    (qd == 2'h1) && !init_pulse |=> s_r.enc == $past(s_r.enc) + 24'h00_0001)
    else $error("Clockwise edge did not increment count");
  a_enc_init_clear: assert property (@(posedge clk) disable iff (srst) // [RULE6]
    init_pulse |=> s_r.enc == 24'h00_0000 && s_r.remain == 24'h00_0000)
    else $error("Initialization did not clear counters");
  a_div_reload: assert property (@(posedge clk) disable iff (srst) // [RULE8]
    div_tick && !init_pulse |=> s_r.div_cnt == $past(s_r.div_val))
    else $error("Divider did not reload its value");
  a_ext_source_only: assert property (@(posedge clk) disable iff (srst) // [RULE9]
    s_r.step && !$past(s_r.ref_sel) |-> $past(s_r.x_s2 && !s_r.x_prev))
    else $error("Step without external edge on external source");

endmodule : encdiv_chan

// ==== encdiv_top.sv ====
// Two-channel encoder counter and step divider with command port
`timescale 1ns/10ps
`include "encdiv_consts.svh"

module encdiv_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [1:0]  enc_a,
  input  wire logic [1:0]  enc_b,
  input  wire logic [1:0]  ext_step,
  input  wire logic        cmd_valid,
  input  wire logic [5:0]  cmd_code,
  input  wire logic        cmd_chan,
  input  wire logic [23:0] cmd_data,
  output logic             rsp_valid,
  output logic             rsp_busy,
  output logic             rsp_err,
  output logic      [23:0] rsp_data,
  output logic      [1:0]  step_out,
  output logic      [1:0]  cmd_done
);

  encdiv_pkg::encdiv_top_t s_r;
  encdiv_pkg::encdiv_top_t s_nxt;

  logic [1:0][23:0] enc_cnt;
  logic [1:0][23:0] remain;
  logic [1:0]       moving;
  logic [1:0]       done;
  logic [1:0]       init_p;
  logic [1:0]       div_p;
  logic [1:0]       move_p;
  logic             div_ok;

  // Zero or oversize divider values are refused here as a safety net
  assign div_ok = (cmd_data[7:0] >= `ENCDIV_DIV_MIN) &&
                  (cmd_data[23:8] == 16'h0000);

  function automatic logic encdiv_hit(input logic [5:0] code,
                                      input logic       ch,
                                      input logic       idx);
    encdiv_hit = cmd_valid && (cmd_code == code) && (ch == idx);
  endfunction : encdiv_hit

  ////////////////////////////////////////////////////////////////////////
  // [RULE11] Two independent channels
  for (genvar g = 0; g < 2; g++) begin : g_chan
    assign init_p[g] = encdiv_hit(encdiv_pkg::ENCDIV_CMD_INIT, cmd_chan,
                                  1'(g));
    assign div_p[g]  = encdiv_hit(encdiv_pkg::ENCDIV_CMD_DIV, cmd_chan,
                                  1'(g)) && div_ok;
    assign move_p[g] = encdiv_hit(encdiv_pkg::ENCDIV_CMD_MOVE, cmd_chan,
                                  1'(g)) && !moving[g];
    encdiv_chan u_chan (
      .clk          (clk),
      .srst         (srst),
      .enc_a_pin    (enc_a[g]),
      .enc_b_pin    (enc_b[g]),
      .ext_step_pin (ext_step[g]),
      .ref_tick     (s_r.ref_tick),
      .init_pulse   (init_p[g]),
      .init_ref_sel (cmd_data[0]),
      .div_load     (div_p[g]),
      .div_val      (cmd_data[7:0]),
      .move_load    (move_p[g]),
      .move_count   (cmd_data),
      .enc_count    (enc_cnt[g]),
      .remain       (remain[g]),
      .moving       (moving[g]),
      .step_pulse   (step_out[g]),
      .done_pulse   (done[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt           = s_r;
    s_nxt.rsp_valid = 1'b0;
    // 100 kHz reference as a one-cycle enable
    s_nxt.ref_tick  = (s_r.pre_cnt == `ENCDIV_PRE_MAX);
    s_nxt.pre_cnt   = s_nxt.ref_tick ? 10'h000 : s_r.pre_cnt + 10'h001;
    if (cmd_valid) begin
      s_nxt.rsp_valid = 1'b1;
      s_nxt.rsp_busy  = 1'b0;
      s_nxt.rsp_err   = 1'b0;
      // Any command breaks a run of finish reads
      s_nxt.fin_seen  = 2'b00;
      unique case (cmd_code)
        encdiv_pkg::ENCDIV_CMD_MOVE: begin
          s_nxt.rsp_busy = moving[cmd_chan];
        end
        encdiv_pkg::ENCDIV_CMD_STATUS: begin
          // [RULE1] Busy keeps last status
          if (moving[cmd_chan]) begin
            s_nxt.rsp_busy = 1'b1;
            s_nxt.rsp_data = s_r.stat[cmd_chan];
          end else begin
            // [RULE2] Report remaining steps
            s_nxt.stat[cmd_chan] = remain[cmd_chan];
            s_nxt.rsp_data       = remain[cmd_chan];
          end
        end
        encdiv_pkg::ENCDIV_CMD_ENC: begin
          // [RULE5] Live byte, no snapshot
          unique case (cmd_data[1:0])
            2'h0:    s_nxt.rsp_data = {16'h0000, enc_cnt[cmd_chan][7:0]};
            2'h1:    s_nxt.rsp_data = {16'h0000, enc_cnt[cmd_chan][15:8]};
            2'h2:    s_nxt.rsp_data = {16'h0000, enc_cnt[cmd_chan][23:16]};
            default: s_nxt.rsp_err  = 1'b1;
          endcase
        end
        encdiv_pkg::ENCDIV_CMD_FIN: begin
          // [RULE12] Second read clears flag
          s_nxt.rsp_data = {23'h00_0000, s_r.fin[cmd_chan]};
          if (s_r.fin_seen[cmd_chan]) begin
            s_nxt.fin[cmd_chan] = 1'b0;
          end else begin
            s_nxt.fin_seen[cmd_chan] = 1'b1;
          end
        end
        encdiv_pkg::ENCDIV_CMD_DIV: begin
          s_nxt.rsp_err = !div_ok;
        end
        encdiv_pkg::ENCDIV_CMD_INIT: begin
          s_nxt.fin[cmd_chan] = 1'b1;
        end
        default: begin
          s_nxt.rsp_err = 1'b1;
        end
      endcase
    end
    // [RULE12] Set wins over clear
    for (int i = 0; i < 2; i++) begin
      if (done[i]) begin
        s_nxt.fin[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rsp_valid = s_r.rsp_valid;
  assign rsp_busy  = s_r.rsp_busy;
  assign rsp_err   = s_r.rsp_err;
  assign rsp_data  = s_r.rsp_data;
  assign cmd_done  = s_r.fin;

  ////////////////////////////////////////////////////////////////////////
  sequence s_fin_read(logic ch);
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_FIN && cmd_chan == ch;
  endsequence

  sequence s_fin_twice(logic ch);
    s_fin_read(ch) ##1 s_fin_read(ch);
  endsequence

  a_fin_second_clear: assert property (@(posedge clk) disable iff (srst) // [RULE12]
    s_fin_twice(1'b0) ##0 !done[0] |=> !s_r.fin[0])
    else $error("Finish flag survived second read");
  a_fin_first_keep: assert property (@(posedge clk) disable iff (srst) // [RULE12]
    !s_r.fin_seen[0] && s_r.fin[0] ##0 s_fin_read(1'b0) |=> s_r.fin[0])
    else $error("Finish flag cleared by first read");
  a_fin_done_set: assert property (@(posedge clk) disable iff (srst) // [RULE12]
    done[1] |=> s_r.fin[1])
    else $error("Completion did not set finish flag");
  a_status_busy_keep: assert property (@(posedge clk) disable iff (srst) // [RULE1]
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_STATUS && moving[cmd_chan]
    |=> rsp_busy && rsp_data == $past(s_r.stat[cmd_chan]))
    else $error("Status read while moving not refused");
  a_status_remain: assert property (@(posedge clk) disable iff (srst) // [RULE2]
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_STATUS && !moving[cmd_chan]
    |=> !rsp_busy && rsp_data == $past(remain[cmd_chan]))
    else $error("Status read did not return remaining steps");
  a_enc_chan_byte: assert property (@(posedge clk) disable iff (srst) // [RULE11]
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_ENC && cmd_data[1:0] == 2'h2
    |=> rsp_data[7:0] == $past(enc_cnt[cmd_chan][23:16]))
    else $error("Encoder byte from wrong channel or lane");
  a_ref_period: assert property (@(posedge clk) disable iff (srst) // [RULE9]
    s_r.ref_tick |=> !s_r.ref_tick [*8])
    else $error("Reference enable too frequent");

  a_rsp_answer: assert property ( // [RULE11]
    @(posedge clk) disable iff (srst)
    cmd_valid |=> rsp_valid)
    else $error("Command got no answer");

  a_move_refuse: assert property ( // [RULE2]
    @(posedge clk) disable iff (srst)
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_MOVE && moving[cmd_chan]
    |=> rsp_busy)
    else $error("Move while moving not refused");

  a_div_refuse: assert property ( // [RULE10]
    @(posedge clk) disable iff (srst)
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_DIV &&
    (cmd_data[7:0] == 8'h00 || cmd_data[23:8] != 16'h0000)
    |=> rsp_err)
    else $error("Illegal divider load not refused");

  a_div_accept: assert property ( // [RULE10]
    @(posedge clk) disable iff (srst)
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_DIV &&
    cmd_data[7:0] != 8'h00 && cmd_data[23:8] == 16'h0000
    |=> !rsp_err)
    else $error("Legal divider load refused");

  a_status_store_keep: assert property ( // [RULE1]
    @(posedge clk) disable iff (srst)
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_STATUS &&
    moving[cmd_chan]
    |=> s_r.stat[$past(cmd_chan)] == $past(s_r.stat[cmd_chan]))
    else $error("Stored status changed while moving");

  a_enc_byte_low: assert property ( // [RULE5]
    @(posedge clk) disable iff (srst)
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_ENC &&
    cmd_data[1:0] == 2'h0
    |=> rsp_data == {16'h0000, $past(enc_cnt[cmd_chan][7:0])})
    else $error("Encoder low byte wrong");

  a_enc_byte_mid: assert property ( // [RULE5]
    @(posedge clk) disable iff (srst)
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_ENC &&
    cmd_data[1:0] == 2'h1
    |=> rsp_data == {16'h0000, $past(enc_cnt[cmd_chan][15:8])})
    else $error("Encoder middle byte wrong");

  a_enc_bad_index: assert property ( // [RULE5]
    @(posedge clk) disable iff (srst)
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_ENC &&
    cmd_data[1:0] == 2'h3
    |=> rsp_err)
    else $error("Encoder byte index three not refused");

  a_fin_done_a: assert property ( // [RULE12]
    @(posedge clk) disable iff (srst)
    done[0] |=> s_r.fin[0])
    else $error("Completion did not set first finish flag");

  a_init_fin_set: assert property ( // [RULE12]
    @(posedge clk) disable iff (srst)
    cmd_valid && cmd_code == encdiv_pkg::ENCDIV_CMD_INIT
    |=> s_r.fin[$past(cmd_chan)])
    else $error("Initialization did not set finish flag");

endmodule : encdiv_top

// ==== encdiv_enc_model.sv ====
// Incremental encoder model driving one quadrature pair
`timescale 1ns/10ps

module encdiv_enc_model (
  input  wire logic clk,
  output logic      enc_a,
  output logic      enc_b
);
  logic [1:0] ph_r;

  initial begin
    ph_r  = 2'b00;
    enc_a = 1'b0;
    enc_b = 1'b0;
  end

  // Gray steps, clockwise walks 00-01-11-10
  // Slow edges keep every phase well past the input synchronizers
  task automatic turn(input logic cw, input int n);
    logic [1:0] g;
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge clk);
      ph_r = cw ? ph_r + 2'b01 : ph_r - 2'b01;
      g = {ph_r[1], ph_r[1] ^ ph_r[0]};
      enc_a <= g[1];
      enc_b <= g[0];
    end
  endtask : turn
endmodule : encdiv_enc_model

// ==== encoder_counter_and_step_divider_test.sv ====
// Self-checking bench for the encoder counter and step divider
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  failures++; $display("Error %s expected %h seen %h", nm, ex, got); end end

module encoder_counter_and_step_divider_test;
  logic        clk;
  logic        srst;
  wire  [1:0]  enc_a;
  wire  [1:0]  enc_b;
  logic [1:0]  ext_step;
  logic        cmd_valid;
  logic [5:0]  cmd_code;
  logic        cmd_chan;
  logic [23:0] cmd_data;
  logic        rsp_valid;
  logic        rsp_busy;
  logic        rsp_err;
  logic [23:0] rsp_data;
  logic [1:0]  step_out;
  logic [1:0]  cmd_done;
  int          failures;
  int          num_checks;
  int          cyc;
  int          sc0;
  int          sc1;
  int          tp1;
  int          tl1;

  encdiv_top dut_u (.clk(clk), .srst(srst), .enc_a(enc_a), .enc_b(enc_b),
    .ext_step(ext_step), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_chan(cmd_chan), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_busy(rsp_busy), .rsp_err(rsp_err), .rsp_data(rsp_data),
    .step_out(step_out), .cmd_done(cmd_done));
  encdiv_enc_model enc0_u (.clk(clk), .enc_a(enc_a[0]), .enc_b(enc_b[0]));
  encdiv_enc_model enc1_u (.clk(clk), .enc_a(enc_a[1]), .enc_b(enc_b[1]));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (step_out[0] === 1'b1) sc0++;
    if (step_out[1] === 1'b1) begin
      sc1++;
      tp1 = tl1;
      tl1 = cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic cmd(input logic [5:0] c, input logic ch,
                     input logic [23:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_chan  <= ch;
    cmd_data  <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    `CHK("rsp_valid", 1'b1, rsp_valid)
  endtask : cmd

  task automatic rd_enc(input logic ch, input logic [23:0] e);
    for (int i = 0; i < 3; i++) begin
      cmd(encdiv_pkg::ENCDIV_CMD_ENC, ch, 24'(i));
      `CHK("enc byte", e[8*i+:8], rsp_data[7:0])
    end
  endtask : rd_enc

  task automatic t_init();
    cmd(encdiv_pkg::ENCDIV_CMD_INIT, 1'b0, 24'h00_0000);
    cmd(encdiv_pkg::ENCDIV_CMD_INIT, 1'b1, 24'h00_0001);
    `CHK("done init", 2'b11, cmd_done)
    rd_enc(1'b0, 24'h00_0000);
    cmd(encdiv_pkg::ENCDIV_CMD_STATUS, 1'b1, 24'h00_0000);
    `CHK("status", 25'h000_0000, {rsp_busy, rsp_data})
  endtask : t_init

  task automatic t_enc();
    enc0_u.turn(1'b1, 5);
    enc1_u.turn(1'b0, 3);
    // Read only once the encoder is at rest
    repeat (10) @(posedge clk);
    rd_enc(1'b0, 24'h00_0005);
    rd_enc(1'b1, 24'hFF_FFFD);
    cmd(encdiv_pkg::ENCDIV_CMD_ENC, 1'b0, 24'h00_0003);
    `CHK("bad index", 1'b1, rsp_err)
  endtask : t_enc

  task automatic t_fin();
    cmd(encdiv_pkg::ENCDIV_CMD_FIN, 1'b0, 24'h00_0000);
    `CHK("fin first", 2'b11, {rsp_data[0], cmd_done[0]})
    // Another command restarts the run of finish reads
    cmd(encdiv_pkg::ENCDIV_CMD_STATUS, 1'b0, 24'h00_0000);
    cmd(encdiv_pkg::ENCDIV_CMD_FIN, 1'b0, 24'h00_0000);
    `CHK("fin kept", 2'b11, {rsp_data[0], cmd_done[0]})
    cmd(encdiv_pkg::ENCDIV_CMD_STATUS, 1'b0, 24'h00_0000);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code  <= encdiv_pkg::ENCDIV_CMD_FIN;
    cmd_chan  <= 1'b0;
    repeat (2) @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("fin clear", 1'b0, cmd_done[0])
  endtask : t_fin

  task automatic t_move_ext();
    cmd(encdiv_pkg::ENCDIV_CMD_MOVE, 1'b0, 24'h00_0003);
    repeat (2) @(posedge clk);
    cmd(encdiv_pkg::ENCDIV_CMD_STATUS, 1'b0, 24'h00_0000);
    `CHK("busy stat", 25'h100_0000, {rsp_busy, rsp_data})
    cmd(encdiv_pkg::ENCDIV_CMD_MOVE, 1'b0, 24'h00_0005);
    `CHK("move busy", 1'b1, rsp_busy)
    cmd(encdiv_pkg::ENCDIV_CMD_DIV, 1'b0, 24'h00_00FF);
    `CHK("div 255", 1'b0, rsp_err)
    repeat (3000) @(posedge clk);
    `CHK("no ref step", 0, sc0)
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      ext_step[0] <= 1'b1;
      repeat (4) @(posedge clk);
      ext_step[0] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (10) @(posedge clk);
    `CHK("ext steps", 3, sc0)
    `CHK("done move", 1'b1, cmd_done[0])
    cmd(encdiv_pkg::ENCDIV_CMD_STATUS, 1'b0, 24'h00_0000);
    `CHK("rest stat", 25'h000_0000, {rsp_busy, rsp_data})
    rd_enc(1'b0, 24'h00_0005);
  endtask : t_move_ext

  task automatic t_div_ref();
    cmd(encdiv_pkg::ENCDIV_CMD_DIV, 1'b1, 24'h00_0000);
    `CHK("div zero", 1'b1, rsp_err)
    cmd(encdiv_pkg::ENCDIV_CMD_DIV, 1'b1, 24'h00_0100);
    `CHK("div 256", 1'b1, rsp_err)
    // Legal load, host range 1 to 255
    cmd(encdiv_pkg::ENCDIV_CMD_DIV, 1'b1, 24'h00_0001);
    cmd(encdiv_pkg::ENCDIV_CMD_MOVE, 1'b1, 24'h00_0002);
    for (int i = 0; i < 6000 && sc1 < 2; i++) @(posedge clk);
    `CHK("ref steps", 2, sc1)
    `CHK("step gap", 2000, tl1 - tp1)
    rd_enc(1'b1, 24'hFF_FFFD);
  endtask : t_div_ref

  task automatic results();
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    ext_step = 2'b00;
    cmd_valid = 1'b0;
    cmd_code = 6'h00;
    cmd_chan = 1'b0;
    cmd_data = 24'h00_0000;
    failures = 0;
    num_checks = 0;
    cyc = 0;
    sc0 = 0;
    sc1 = 0;
    tp1 = 0;
    tl1 = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_init();
    t_enc();
    t_fin();
    t_move_ext();
    t_div_ref();
    results();
  end

  // Generous bound: whole sequence needs under 12000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    results();
  end
endmodule : encoder_counter_and_step_divider_test
